// ==== hw/pmlc_top.sv ====
// Operating mode, isolate and loopback control of the 10/100 PHY
//
// Contract
// - Repeater bit set: carrier sense from receive only
// - Node mode: carrier sense from receive or transmit; the code uses receive only in full duplex
// - Repeater bit default taken from hub strap
// - Repeater at 100: carrier integrity check enabled
// - No repeater behaviour at 10 Mb/s
// - Isolate defaults set when strap address zero
// - Isolate ignores transmit inputs, floats MII outputs
// - Management access keeps working while isolated
// - Isolated line sends idles, no packet data
// - Loopback returns transmit data, media transmit off
// - Status register shows loopback active
// - Normal 10 Mb/s echoes transmit onto receive
// - 100 Mb/s loopback returns through line layers
// - Loopback write forces loop select to zero
// - Loop select resets to fiber when strap active
// - Loopback write clears digital loopback bit
// - Loopback forces both transceiver loopback bits
// - 100 Mb/s transmit clock is bit clock/5
// - 10 Mb/s transmit clock divides by 8/2
// - 10 Mb/s receive as nibbles or serial
// - Carrier sense on incoming 10 Mb/s stream
// - Fiber strap active low at reset
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pmlc_regs.svh"
module pmlc_top (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic [4:0]             addr_in,
  input  wire logic [15:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [15:0]            rdata_out,
  input  wire pmlc_pkg::pmlc_strap_s  strap_in,
  input  wire pmlc_pkg::pmlc_mii_tx_s mii_tx_in,
  output pmlc_pkg::pmlc_mii_rx_s      mii_rx_out,
  output logic                        mii_oe_out,
  output logic      [3:0]             mii_rxd_oe_out,
  output logic                        tx_clk_out,
  input  wire logic                   bit_tick_in,
  input  wire logic                   osc_tick_in,
  input  wire pmlc_pkg::pmlc_line_rx_s line_rx_in,
  output pmlc_pkg::pmlc_mii_tx_s      line_tx_out,
  output logic                        line_media_en_out,
  output logic                        carrier_integrity_check_out,
  output logic      [2:0]             hundred_loop_select_out,
  output logic                        dig_loop_out,
  output logic                        fast_transceiver_loop_out,
  output logic                        slow_transceiver_loop_out
);
  import pmlc_pkg::*;

  typedef struct packed {
    pmlc_phase_e   phase;
    logic [2:0]    wait_cnt;
    logic          loop;
    logic          speed100;
    logic          iso;
    logic          fdx;
    logic          rep_sel;
    logic [2:0]    loop_sel;
    logic          dig;
    logic          fast;
    logic          slow;
    logic          serial10;
    logic          bad_ssd;
    logic [15:0]   rdata;
    pmlc_mii_rx_s  rx;
    logic          oe;
    logic [3:0]    rxd_oe;
    logic          tx_clk;
    pmlc_mii_tx_s  ltx;
    logic          media_en;
    logic          chk_en;
    logic [2:0]    lsel_o;
    logic          dig_o;
    logic          fast_o;
    logic          slow_o;
  } pmlc_top_s;

  pmlc_top_s     s_r, s_nxt;
  pmlc_strap_s   strap_q;
  logic          div_clk;
  logic [3:0]    div_sel;
  logic          div_tick;

  // Decode helper used by every register access
  function automatic logic hit(input logic [4:0] a, input logic [4:0] t);
    hit = (a == t);
  endfunction

  function automatic logic [15:0] read_mux(input pmlc_top_s st, input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (hit(a, `PMLC_ADDR_BCR)) begin
      v[`PMLC_BCR_LOOP]  = st.loop;
      v[`PMLC_BCR_SPEED] = st.speed100;
      v[`PMLC_BCR_ISO]   = st.iso;
      v[`PMLC_BCR_FDX]   = st.fdx;
    end else if (hit(a, `PMLC_ADDR_STAT)) begin
      v[`PMLC_STAT_LOOP] = st.loop;
      v[`PMLC_STAT_CHK]  = st.rep_sel & st.speed100;
      v[`PMLC_STAT_BAD]  = st.bad_ssd;
    end else if (hit(a, `PMLC_ADDR_LOOPBYP)) begin
      v[`PMLC_LOOPBYP_LSEL_HI:`PMLC_LOOPBYP_LSEL_LO] = st.loop_sel;
      v[`PMLC_LOOPBYP_DIG]  = st.dig;
      v[`PMLC_LOOPBYP_FAST] = st.fast | st.loop;
      v[`PMLC_LOOPBYP_SLOW] = st.slow | st.loop;
    end else if (hit(a, `PMLC_ADDR_TSCR)) begin
      v[`PMLC_TSCR_SER] = st.serial10;
    end else if (hit(a, `PMLC_ADDR_PHYCFG)) begin
      v[`PMLC_PHYCFG_REP] = st.rep_sel;
    end
    read_mux = v;
  endfunction

  // Straps are pins, so they pass the pin synchroniser first
  pmlc_sync #(
    .W(7)
  ) u_strap_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (strap_in),
    .q_out   (strap_q)
  );

  always_comb begin
    if (s_r.speed100) begin
      div_sel  = `PMLC_DIV_100;
      div_tick = bit_tick_in;
    end else begin
      div_sel  = s_r.serial10 ? `PMLC_DIV_SER : `PMLC_DIV_NIB;
      div_tick = osc_tick_in;
    end
  end

  pmlc_clkdiv u_txclk_div (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .tick_in (div_tick),
    .div_in  (div_sel),
    .clk_out (div_clk)
  );

  always_comb begin
    pmlc_mii_tx_s tx;
    logic         rx_act;
    logic         rx_only;
    logic         echo10;
    s_nxt  = s_r;
    tx     = '0;
    rx_act = 1'b0;
    rx_only = 1'b0;
    echo10 = 1'b0;

    // Strap capture once, after the synchroniser has settled
    case (s_r.phase)
      PMLC_PH_WAIT: begin
        if (s_r.wait_cnt == `PMLC_CAP_CNT) begin
          s_nxt.phase    = PMLC_PH_RUN;
          s_nxt.rep_sel  = strap_q.hub_role;
          s_nxt.iso      = (strap_q.phy_addr == `PMLC_STRAP_ISO_ADR);
          s_nxt.loop_sel = strap_q.fiber_n ? `PMLC_LSEL_NORM : `PMLC_LSEL_FIBER;
        end else begin
          s_nxt.wait_cnt = s_r.wait_cnt + 3'h1;
        end
      end
      PMLC_PH_RUN: begin
        s_nxt.phase = PMLC_PH_RUN;
      end
      default: begin
        s_nxt.phase = PMLC_PH_WAIT;
      end
    endcase

    // Register writes are served in every mode, isolate included
    if (wr_in) begin
      if (hit(addr_in, `PMLC_ADDR_BCR)) begin
        s_nxt.loop     = wdata_in[`PMLC_BCR_LOOP];
        s_nxt.speed100 = wdata_in[`PMLC_BCR_SPEED];
        s_nxt.iso      = wdata_in[`PMLC_BCR_ISO];
        s_nxt.fdx      = wdata_in[`PMLC_BCR_FDX];
        s_nxt.loop_sel = `PMLC_LSEL_NORM;
        s_nxt.dig      = 1'b0;
      end
      if (hit(addr_in, `PMLC_ADDR_LOOPBYP)) begin
        s_nxt.loop_sel = wdata_in[`PMLC_LOOPBYP_LSEL_HI:`PMLC_LOOPBYP_LSEL_LO];
        s_nxt.dig      = wdata_in[`PMLC_LOOPBYP_DIG];
        s_nxt.fast     = wdata_in[`PMLC_LOOPBYP_FAST];
        s_nxt.slow     = wdata_in[`PMLC_LOOPBYP_SLOW];
      end
      if (hit(addr_in, `PMLC_ADDR_TSCR)) begin
        s_nxt.serial10 = wdata_in[`PMLC_TSCR_SER];
      end
      if (hit(addr_in, `PMLC_ADDR_PHYCFG)) begin
        s_nxt.rep_sel = wdata_in[`PMLC_PHYCFG_REP];
      end
    end

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = rd_in ? read_mux(s_r, addr_in) : 16'h0000;

    // Bad delimiter flag clears on status read; a new event wins
    if (rd_in && hit(addr_in, `PMLC_ADDR_STAT)) begin
      s_nxt.bad_ssd = 1'b0;
    end
    if (s_r.rep_sel && s_r.speed100 && line_rx_in.bad_ssd) begin
      s_nxt.bad_ssd = 1'b1;
    end

    // Isolated: transmit pins are treated as idle
    tx = s_r.iso ? '0 : mii_tx_in;

    // Receive side toward the MAC
    s_nxt.rx = '0;
    if (s_r.speed100) begin
      // Loopback data come back from the line layers on the rx path
      s_nxt.rx.dv = line_rx_in.dv;
      s_nxt.rx.er = line_rx_in.er;
      s_nxt.rx.d  = line_rx_in.d;
      rx_act      = line_rx_in.dv;
    end else begin
      echo10 = tx.en | s_r.loop;
      if (echo10) begin
        s_nxt.rx.dv = tx.en;
        s_nxt.rx.er = tx.er;
        s_nxt.rx.d  = tx.d;
        rx_act      = s_r.loop ? tx.en : line_rx_in.dv;
      end else begin
        s_nxt.rx.dv = line_rx_in.dv;
        s_nxt.rx.er = line_rx_in.er;
        s_nxt.rx.d  = line_rx_in.d;
        rx_act      = line_rx_in.dv;
      end
      if (s_r.serial10) begin
        s_nxt.rx.d = {3'h0, s_nxt.rx.d[0]};
      end
    end

    // Repeater carrier sense only applies at 100 Mb/s
    rx_only     = s_r.fdx | (s_r.rep_sel & s_r.speed100);
    s_nxt.rx.crs = rx_act | (~rx_only & tx.en);
    s_nxt.rx.col = ~s_r.fdx & ~s_r.loop & line_rx_in.col;

    // Drivers of the MII outputs
    s_nxt.oe     = ~s_r.iso;
    if (s_r.iso) begin
      s_nxt.rxd_oe = 4'h0;
    end else if (s_r.serial10 && !s_r.speed100) begin
      s_nxt.rxd_oe = 4'h1;
    end else begin
      s_nxt.rxd_oe = 4'hf;
    end
    s_nxt.tx_clk = div_clk;

    // Line side: idles or link pulses keep going while isolated
    s_nxt.ltx      = tx;
    s_nxt.media_en = ~s_r.loop;
    s_nxt.chk_en   = s_r.rep_sel & s_r.speed100;
    s_nxt.lsel_o   = s_r.loop_sel;
    s_nxt.dig_o    = s_r.dig;
    s_nxt.fast_o   = s_r.fast | s_r.loop;
    s_nxt.slow_o   = s_r.slow | s_r.loop;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r          <= '0;
      s_r.phase    <= PMLC_PH_WAIT;
      s_r.speed100 <= `PMLC_RST_SPEED;
      // Held isolated until the address strap is known
      s_r.iso      <= `PMLC_RST_ISO;
      s_r.rep_sel  <= `PMLC_RST_REP;
      s_r.loop_sel <= `PMLC_LSEL_NORM;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out                   = s_r.rdata;
  assign mii_rx_out                  = s_r.rx;
  assign mii_oe_out                  = s_r.oe;
  assign mii_rxd_oe_out              = s_r.rxd_oe;
  assign tx_clk_out                  = s_r.tx_clk;
  assign line_tx_out                 = s_r.ltx;
  assign line_media_en_out           = s_r.media_en;
  assign carrier_integrity_check_out = s_r.chk_en;
  assign hundred_loop_select_out     = s_r.lsel_o;
  assign dig_loop_out                = s_r.dig_o;
  assign fast_transceiver_loop_out   = s_r.fast_o;
  assign slow_transceiver_loop_out   = s_r.slow_o;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_node_crs;
    (!s_r.iso && !s_r.rep_sel && !s_r.fdx && mii_tx_in.en) |=> mii_rx_out.crs;
  endproperty
  a_node_crs: assert property (p_node_crs) else $error("node crs missing on transmit");

  property p_rep_crs;
    (s_r.rep_sel && s_r.speed100 && !line_rx_in.dv) |=> !mii_rx_out.crs;
  endproperty
  a_rep_crs: assert property (p_rep_crs) else $error("repeater crs without receive");

  property p_iso_float;
    s_r.iso |=> (!mii_oe_out && mii_rxd_oe_out == 4'h0 && !line_tx_out.en);
  endproperty
  a_iso_float: assert property (p_iso_float) else $error("isolate left outputs driven");

  property p_iso_idle;
    (s_r.iso && !s_r.loop) |=> line_media_en_out ##0 !line_tx_out.en;
  endproperty
  a_iso_idle: assert property (p_iso_idle) else $error("isolate stopped idles");

  property p_loop_stat;
    (rd_in && addr_in == `PMLC_ADDR_STAT) |=> rdata_out[`PMLC_STAT_LOOP] == $past(s_r.loop);
  endproperty
  a_loop_stat: assert property (p_loop_stat) else $error("loop status wrong");

  property p_loop_clr_sel;
    (wr_in && addr_in == `PMLC_ADDR_BCR) |=> ##1 hundred_loop_select_out == `PMLC_LSEL_NORM;
  endproperty
  a_loop_clr_sel: assert property (p_loop_clr_sel) else $error("loop select not cleared");

  property p_loop_clr_dig;
    (wr_in && addr_in == `PMLC_ADDR_BCR) |=> !s_r.dig ##1 !dig_loop_out;
  endproperty
  a_loop_clr_dig: assert property (p_loop_clr_dig) else $error("digital loop not cleared");

  property p_xcv_loop;
    s_r.loop |=> (fast_transceiver_loop_out && slow_transceiver_loop_out && !line_media_en_out);
  endproperty
  a_xcv_loop: assert property (p_xcv_loop) else $error("loopback side bits wrong");

  property p_chk_en;
    s_r.phase == PMLC_PH_RUN |=> carrier_integrity_check_out == $past(s_r.rep_sel && s_r.speed100);
  endproperty
  a_chk_en: assert property (p_chk_en) else $error("integrity check enable wrong");

  c_capture: cover property (s_r.phase == PMLC_PH_WAIT ##1 s_r.phase == PMLC_PH_RUN);
  c_iso:     cover property (s_r.iso && mii_tx_in.en);
  c_loop:    cover property (s_r.loop && mii_tx_in.en ##1 mii_rx_out.dv);
endmodule // pmlc_top
`default_nettype wire

// ==== hw/pmlc_regs.svh ====
// Register offsets, field positions, reset values and counts for the mode control block
`ifndef PMLC_REGS_SVH
`define PMLC_REGS_SVH

`define PMLC_ADDR_BCR        5'h00
`define PMLC_ADDR_STAT       5'h10
`define PMLC_ADDR_LOOPBYP    5'h17
`define PMLC_ADDR_TSCR       5'h18
`define PMLC_ADDR_PHYCFG     5'h19

`define PMLC_BCR_LOOP        14
`define PMLC_BCR_SPEED       13
`define PMLC_BCR_ISO         10
`define PMLC_BCR_FDX         8
`define PMLC_PHYCFG_REP      9
`define PMLC_LOOPBYP_LSEL_HI 9
`define PMLC_LOOPBYP_LSEL_LO 7
`define PMLC_LOOPBYP_DIG     6
`define PMLC_LOOPBYP_FAST    5
`define PMLC_LOOPBYP_SLOW    4
`define PMLC_TSCR_SER        11
`define PMLC_STAT_LOOP       3
`define PMLC_STAT_CHK        1
`define PMLC_STAT_BAD        0

`define PMLC_LSEL_NORM       3'h0
`define PMLC_LSEL_FIBER      3'h3
`define PMLC_STRAP_ISO_ADR   5'h00
`define PMLC_RST_SPEED       1'h1
`define PMLC_RST_ISO         1'h1
`define PMLC_RST_REP         1'h1

`define PMLC_DIV_100         4'h5
`define PMLC_DIV_NIB         4'h8
`define PMLC_DIV_SER         4'h2
// Synchroniser output settles at edge four, so capture one edge later
`define PMLC_CAP_CNT         3'h4

`endif

// ==== hw/pmlc_pkg.sv ====
// Types shared by the mode control block and its helpers
package pmlc_pkg;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } pmlc_mii_tx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
    logic       crs;
    logic       col;
  } pmlc_mii_rx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
    logic       col;
    logic       bad_ssd;
  } pmlc_line_rx_s;

  typedef struct packed {
    logic       hub_role;
    logic       fiber_n;
    logic [4:0] phy_addr;
  } pmlc_strap_s;

  typedef enum logic {PMLC_PH_WAIT, PMLC_PH_RUN} pmlc_phase_e;

endpackage

// ==== hw/pmlc_sync.sv ====
// Three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pmlc_sync #(
  parameter int W = 7
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] c;
    logic [W-1:0] q;
  } pmlc_sync_s;

  pmlc_sync_s s_r, s_nxt;

  always_comb begin
    s_nxt   = s_r;
    s_nxt.a = d_in;
    s_nxt.b = s_r.a;
    s_nxt.c = s_r.b;
    // Stage a is only ever read by stage b
    if (s_r.b == s_r.c) begin
      s_nxt.q = s_r.c;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.q;
endmodule // pmlc_sync
`default_nettype wire

// ==== hw/pmlc_clkdiv.sv ====
// Tick counter that divides a fast clock strobe into the MII transmit clock
`timescale 1ns/100ps
`default_nettype none
module pmlc_clkdiv (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       tick_in,
  input  wire logic [3:0] div_in,
  output logic            clk_out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       clk;
  } pmlc_div_s;

  pmlc_div_s s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (tick_in) begin
      // Wrap test with >= so a smaller divisor never strands the count
      if (s_r.cnt >= div_in - 4'h1) begin
        s_nxt.cnt = 4'h0;
      end else begin
        s_nxt.cnt = s_r.cnt + 4'h1;
      end
      s_nxt.clk = (s_nxt.cnt < (div_in >> 1));
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clk_out = s_r.clk;
endmodule // pmlc_clkdiv
`default_nettype wire

// ==== verif/pmlc_mac_model.sv ====
// MAC-side transmit model driving nibbles onto the MII
`timescale 1ns/100ps
`default_nettype none
module pmlc_mac_model (
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  input  wire logic               go_in,
  input  wire logic [3:0]         nib_in,
  output pmlc_pkg::pmlc_mii_tx_s  tx_out
);
  import pmlc_pkg::*;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_out <= '0;
    end else if (go_in) begin
      tx_out <= '{en: 1'b1, er: 1'b0, d: nib_in};
    end else begin
      // Idle data keeps moving so a missed enable qualifier shows up
      tx_out <= '{en: 1'b0, er: 1'b0, d: ~tx_out.d};
    end
  end
endmodule // pmlc_mac_model
`default_nettype wire

// ==== verif/tb_pmlc_top.sv ====
// Self-checking bench for the mode, isolate and loopback control block
`timescale 1ns/100ps
`default_nettype none
module tb_pmlc_top;
  import pmlc_pkg::*;
  logic          clk_in  = 1'b0;
  logic          nrst_in = 1'b0;
  logic [4:0]    addr    = 5'h00;
  logic [15:0]   wdata   = 16'h0000;
  logic          wr_s    = 1'b0;
  logic          rd_s    = 1'b0;
  logic [15:0]   rdata;
  pmlc_strap_s   strap   = '{hub_role: 1'b1, fiber_n: 1'b0, phy_addr: 5'h00};
  pmlc_mii_tx_s  mac_tx;
  pmlc_mii_rx_s  mii_rx;
  pmlc_line_rx_s line_rx = '0;
  pmlc_mii_tx_s  line_tx;
  logic          go      = 1'b0;
  logic [3:0]    nib     = 4'h0;
  logic          oe, tx_clk, media_en, integ, dig, fl, sl;
  logic [3:0]    rxd_oe;
  logic [2:0]    hls;
  int            cyc, err_count, samples_checked, n;

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) cyc++;

  pmlc_mac_model pmlc_mac_model_inst (.clk_in(clk_in), .nrst_in(nrst_in), .go_in(go), .nib_in(nib), .tx_out(mac_tx));

  pmlc_top pmlc_top_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
    .rdata_out(rdata), .strap_in(strap), .mii_tx_in(mac_tx), .mii_rx_out(mii_rx), .mii_oe_out(oe),
    .mii_rxd_oe_out(rxd_oe), .tx_clk_out(tx_clk), .bit_tick_in(1'b1), .osc_tick_in(1'b1),
    .line_rx_in(line_rx), .line_tx_out(line_tx), .line_media_en_out(media_en),
    .carrier_integrity_check_out(integ), .hundred_loop_select_out(hls), .dig_loop_out(dig),
    .fast_transceiver_loop_out(fl), .slow_transceiver_loop_out(sl));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_in);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    chk(nm, e, rdata & m);
  endtask

  // Register writes need two edges to reach the outputs, MAC path two as well
  task automatic stl;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic mac(input logic g, input logic [3:0] d);
    @(posedge clk_in);
    go <= g; nib <= d;
  endtask

  task automatic lrx(input logic v, input logic [3:0] d);
    @(posedge clk_in);
    line_rx <= '{dv: v, er: 1'b0, d: d, col: 1'b0, bad_ssd: 1'b0};
  endtask

  task automatic per(output int p);
    int t;
    @(posedge tx_clk);
    t = cyc;
    @(posedge tx_clk);
    p = cyc - t;
  endtask

  task automatic rst(input logic h, input logic f, input logic [4:0] a);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    strap <= '{hub_role: h, fiber_n: f, phy_addr: a};
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    // Straps are captured a few edges after release
    repeat (6) @(posedge clk_in);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end

  initial begin
    rst(1'b1, 1'b0, 5'h00);
    rd("bcr", 5'h00, 16'h6400, 16'h2400);
    rd("lsel", 5'h17, 16'h0380, 16'h0180);
    rd("rep", 5'h19, 16'h0200, 16'h0200);
    #1 chk("integ", 1, integ);
    $display("test defaults done");
    mac(1'b1, 4'h5);
    stl();
    chk("oe", 0, {oe, rxd_oe});
    chk("txen", 0, line_tx.en);
    wr(5'h19, 16'h0000);
    rd("rep", 5'h19, 16'h0200, 16'h0000);
    mac(1'b0, 4'h0);
    $display("test isolate done");
    wr(5'h17, 16'h02c0);
    rd("lsel", 5'h17, 16'h03c0, 16'h02c0);
    wr(5'h00, 16'h2000);
    rd("lsel", 5'h17, 16'h03c0, 16'h0000);
    stl();
    chk("oe", 16'h001f, {oe, rxd_oe});
    $display("test loop clear done");
    mac(1'b1, 4'h3);
    stl();
    chk("crs", 16'h0003, {mii_rx.crs, line_tx.en});
    chk("integ", 0, integ);
    wr(5'h19, 16'h0200);
    stl();
    chk("crs", 0, mii_rx.crs);
    chk("integ", 1, integ);
    lrx(1'b1, 4'h0);
    stl();
    chk("crs", 1, mii_rx.crs);
    @(posedge clk_in);
    line_rx.bad_ssd <= 1'b1;
    @(posedge clk_in);
    line_rx.bad_ssd <= 1'b0;
    rd("bad ssd", 5'h10, 16'h0001, 16'h0001);
    rd("bad clr", 5'h10, 16'h0001, 16'h0000);
    mac(1'b0, 4'h0);
    $display("test carrier done");
    wr(5'h00, 16'h6000);
    lrx(1'b1, 4'h9);
    stl();
    chk("loop", 16'h0003, {media_en, hls, dig, fl, sl});
    chk("rxd", 16'h0019, {mii_rx.dv, mii_rx.d});
    rd("stat", 5'h10, 16'h0008, 16'h0008);
    rd("tloop", 5'h17, 16'h0030, 16'h0030);
    wr(5'h00, 16'h2000);
    lrx(1'b0, 4'h0);
    rd("stat", 5'h10, 16'h0008, 16'h0000);
    #1 chk("media", 1, media_en);
    $display("test loop 100 done");
    wr(5'h00, 16'h0000);
    mac(1'b1, 4'h6);
    stl();
    chk("integ", 0, integ);
    chk("echo", 16'h006d, {mii_rx.crs, mii_rx.dv, mii_rx.d, line_tx.en});
    mac(1'b0, 4'h0);
    lrx(1'b1, 4'h0);
    stl();
    chk("crs", 1, mii_rx.crs);
    lrx(1'b0, 4'h0);
    wr(5'h00, 16'h4000);
    mac(1'b1, 4'ha);
    stl();
    chk("loop10", 16'h001a, {media_en, mii_rx.dv, mii_rx.d});
    mac(1'b0, 4'h0);
    $display("test 10M done");
    wr(5'h00, 16'h0000);
    stl();
    per(n);
    chk("div nib", 8, n[15:0]);
    chk("rxd oe", 16'h000f, rxd_oe);
    wr(5'h18, 16'h0800);
    stl();
    per(n);
    chk("div ser", 2, n[15:0]);
    chk("rxd oe", 16'h0001, rxd_oe);
    wr(5'h00, 16'h2000);
    stl();
    per(n);
    chk("div 100", 5, n[15:0]);
    $display("test clocks done");
    rst(1'b0, 1'b1, 5'h03);
    strap <= '{hub_role: 1'b1, fiber_n: 1'b0, phy_addr: 5'h00};
    rd("bcr", 5'h00, 16'h0400, 16'h0000);
    rd("lsel", 5'h17, 16'h0380, 16'h0000);
    rd("rep", 5'h19, 16'h0200, 16'h0000);
    #1 chk("node", 16'h0001, {integ, oe});
    $display("test node straps done");
    give_verdict();
  end
endmodule // tb_pmlc_top
`default_nettype wire
